//--- src/lcdps_pkg.sv
package lcdps_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int RESET_US     = 10;
  localparam int RESET_CYC    = RESET_US * CLK_MHZ;
  localparam int PWR_WAIT_US  = 20;
  localparam int PWR_WAIT_CYC = PWR_WAIT_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Reset values, icon address range and init-sequence write values
  // ---------------------------------------------------------------
  localparam logic [4:0] VOLUME_RST    = 5'h00;
  localparam logic [4:0] ICON_RST      = 5'h00;
  localparam logic [1:0] DIGITS_RST    = 2'h3;
  localparam logic [7:0] ICON_ADDR_LO  = 8'h20;
  localparam logic [7:0] ICON_ADDR_HI  = 8'h23;
  localparam logic [7:0] BLANK_CHAR    = 8'h20;
  localparam logic [7:0] BLANK_GLYPH   = 8'h00;
  localparam logic [5:0] REV_FIRST_ADR = 6'h3F;

  // ---------------------------------------------------------------
  // Commands and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LCDPS_NOP = 3'h0, LCDPS_SYSSET = 3'h1, LCDPS_VOLUME = 3'h2, LCDPS_PSAVE = 3'h3,
    LCDPS_PWR = 3'h4, LCDPS_DISP = 3'h5, LCDPS_ICON = 3'h6, LCDPS_STATIC = 3'h7
  } lcdps_cmd_e;

  typedef enum logic [1:0] {
    LCDPS_ST_RESET = 2'b00, LCDPS_ST_RUN = 2'b01, LCDPS_ST_SAVE = 2'b11
  } lcdps_state_e;

  typedef struct packed {
    logic       valid;
    lcdps_cmd_e cmd;
    logic [7:0] addr;
    logic [4:0] data;
  } lcdps_cmd_s;

  typedef struct packed {
    logic       comReverse;
    logic       segReverse;
    logic       verticalFlip;
    logic       horizontalFlip;
    logic       glyphRamUsed;
    logic [1:0] digits;
  } lcdps_setup_s;

endpackage : lcdps_pkg

//--- src/lcdps_sync.sv
module lcdps_sync
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  // Three stages; only the agreeing pair moves the output
  logic [2:0] stage_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_q  <= 3'h7; // Pin idles high, so no false edge after reset
      sync_out <= 1'b1;
    end
    else
    begin
      stage_q <= {stage_q[1:0], async_in};
      if (stage_q[2] == stage_q[1])
        sync_out <= stage_q[2];
    end
  end

endmodule : lcdps_sync

//--- src/lcdps_sequencer.sv
// Operation
// - After reset the display, static display, power save and supply are off, setup is three digits normal, volume and icons zero.
// - Memory contents are unknown after reset until written.
// - Dynamic segments light only with display on; static icons follow only the icon data.
// - The external clock runs at the oscillator rate, or four times it on the option, and the internal oscillator runs unless a power save command stops it.
// - Common reverse flips common scan order and segment reverse flips segment order.
// - Vertical flip and horizontal flip bits flip the image accordingly.
module lcdps_sequencer
#(
  parameter bit CLK_X4_OPTION = 1'b0,
  parameter int RESET_CYCLES  = lcdps_pkg::RESET_CYC,
  parameter int PWR_CYCLES    = lcdps_pkg::PWR_WAIT_CYC
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire lcdps_pkg::lcdps_cmd_s  cmdIn,
  input  wire lcdps_pkg::lcdps_setup_s setupIn,
  input  wire logic                   extClk,
  input  wire logic                   useExtClk,
  output lcdps_pkg::lcdps_setup_s     setupOut,
  output logic                        displayOn,
  output logic                        staticDisplayOn,
  output logic                        lowPowerHold,
  output logic                        oscRunning,
  output logic                        supplyOn,
  output logic [4:0]                  volume,
  output logic [3:0][4:0]             iconData,
  output logic                        segmentEnable,
  output logic                        supplySettled,
  output logic                        ready,
  output logic                        dotTick
);

  // ---------------------------------------------------------------
  // Reset settle and supply settle counters
  // ---------------------------------------------------------------
  logic [15:0] rstCnt_q;
  logic [15:0] pwrCnt_q;
  logic        cmdOk;

  // Device ignores commands until its internal reset finishes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstCnt_q <= 16'h0000;
      ready    <= 1'b0;
    end
    else if (rstCnt_q != 16'(RESET_CYCLES - 1))
      rstCnt_q <= rstCnt_q + 16'h0001;
    else
      ready <= 1'b1;
  end

  assign cmdOk = cmdIn.valid && ready;

  // Supply settle flag; restarts on every supply-on
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwrCnt_q      <= 16'h0000;
      supplySettled <= 1'b0;
    end
    else if (!supplyOn)
    begin
      pwrCnt_q      <= 16'h0000;
      supplySettled <= 1'b0;
    end
    else if (pwrCnt_q != 16'(PWR_CYCLES - 1))
      pwrCnt_q <= pwrCnt_q + 16'h0001;
    else
      supplySettled <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Command state
  // ---------------------------------------------------------------
  // Only listed settings reset; memories stay unknown by design
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      displayOn       <= 1'b0;
      staticDisplayOn <= 1'b0;
      lowPowerHold    <= 1'b0;
      oscRunning      <= 1'b1;
      supplyOn        <= 1'b0;
      volume          <= lcdps_pkg::VOLUME_RST;
      iconData        <= {4{lcdps_pkg::ICON_RST}};
      setupOut        <= '{comReverse: 1'b0, segReverse: 1'b0, verticalFlip: 1'b0,
                           horizontalFlip: 1'b0, glyphRamUsed: 1'b0, digits: lcdps_pkg::DIGITS_RST};
    end
    else if (cmdOk)
    begin
      case (cmdIn.cmd)
        lcdps_pkg::LCDPS_SYSSET: setupOut  <= setupIn;
        lcdps_pkg::LCDPS_VOLUME: volume    <= cmdIn.data;
        lcdps_pkg::LCDPS_PSAVE:
        begin
          lowPowerHold <= cmdIn.data[0];
          oscRunning   <= cmdIn.data[1];
        end
        lcdps_pkg::LCDPS_PWR:    supplyOn  <= cmdIn.data[0];
        lcdps_pkg::LCDPS_DISP:   displayOn <= cmdIn.data[0];
        lcdps_pkg::LCDPS_STATIC: staticDisplayOn <= cmdIn.data[0];
        lcdps_pkg::LCDPS_ICON:
        begin
          if (cmdIn.addr >= lcdps_pkg::ICON_ADDR_LO && cmdIn.addr <= lcdps_pkg::ICON_ADDR_HI)
            iconData[cmdIn.addr[1:0]] <= cmdIn.data;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Segment gating
  // ---------------------------------------------------------------
  // Dynamic drive needs display on and no power save
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      segmentEnable <= 1'b0;
    else
      segmentEnable <= displayOn && !lowPowerHold;
  end

  // ---------------------------------------------------------------
  // Dot clock source
  // ---------------------------------------------------------------
  logic       extSync;
  logic       extPrev_q;
  logic [1:0] divCnt_q;
  logic [3:0] oscCnt_q;

  lcdps_sync u_ext_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (extClk),
    .sync_out (extSync)
  );

  // Option build divides the external clock by four
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extPrev_q <= 1'b1; // Matches the synchroniser's idle-high reset
      divCnt_q  <= 2'h0;
      oscCnt_q  <= 4'h0;
      dotTick   <= 1'b0;
    end
    else
    begin
      extPrev_q <= extSync;
      oscCnt_q  <= oscCnt_q + 4'h1;
      dotTick   <= 1'b0;
      if (!oscRunning)
        dotTick <= 1'b0;
      else if (!useExtClk)
        dotTick <= (oscCnt_q == 4'hF);
      else if (extSync && !extPrev_q)
      begin
        divCnt_q <= divCnt_q + 2'h1;
        dotTick  <= CLK_X4_OPTION ? (divCnt_q == 2'h3) : 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_reset_ready_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ready) |-> displayOn == 1'b0 && volume == 5'h00)
    else $error("settings left reset state before ready");

  a_seg_needs_disp: assert property (@(posedge core_clk) disable iff (!rst_n)
    segmentEnable |-> $past(displayOn) && !$past(lowPowerHold))
    else $error("segments lit without display on");

  a_settle_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(supplySettled) |-> supplyOn && $past(supplyOn))
    else $error("supply settled without supply");

  a_setup_loads: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmdOk && cmdIn.cmd == lcdps_pkg::LCDPS_SYSSET |=> setupOut == $past(setupIn))
    else $error("setup not loaded");

  a_psave_osc: assert property (@(posedge core_clk) disable iff (!rst_n)
    !oscRunning |=> !dotTick)
    else $error("dot tick with oscillator stopped");

  a_idle_before_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ready |=> $stable(volume) && $stable(displayOn) && $stable(supplyOn))
    else $error("setting changed before ready");

  a_icon_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(cmdOk && cmdIn.cmd == lcdps_pkg::LCDPS_ICON) |=> $stable(iconData))
    else $error("icon data changed without icon command");

  a_disp_loads: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmdOk && cmdIn.cmd == lcdps_pkg::LCDPS_DISP |=> displayOn == $past(cmdIn.data[0]))
    else $error("display on bit not loaded");

  a_psave_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
    lowPowerHold |=> !segmentEnable)
    else $error("segments lit in power save");

endmodule : lcdps_sequencer

//--- bench/lcdps_host.sv
module lcdps_host
(
  input  wire logic             core_clk,
  input  wire logic             ready,
  output lcdps_pkg::lcdps_cmd_s cmdOut
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Command port
  // ---------------------------------------------------------------
  // Set once the power-up sequence is through; nothing waits for it, the bench only checks it
  logic initDone = 1'b0;
  initial cmdOut = '0;

  // Idle fields are scrambled so a stale command never looks valid
  task automatic send(input lcdps_pkg::lcdps_cmd_e c, input logic [7:0] a, input logic [4:0] d);
    @(posedge core_clk);
    #1;
    cmdOut = '{1'b1, c, a, d};
    @(posedge core_clk);
    #1;
    cmdOut = '{1'b0, lcdps_pkg::lcdps_cmd_e'(~c), ~a, ~d};
  endtask : send

  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  // Icons go out 20H, 22H, then 21H, 23H
  task automatic init_seq(input int pwrWait);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    send(lcdps_pkg::LCDPS_NOP, 8'h00, 5'h00);
    send(lcdps_pkg::LCDPS_SYSSET, 8'h00, 5'h00);
    send(lcdps_pkg::LCDPS_VOLUME, 8'h00, 5'h10);
    send(lcdps_pkg::LCDPS_PSAVE, 8'h00, 5'h02);
    send(lcdps_pkg::LCDPS_PWR, 8'h00, 5'h01);
    // Address set and blanking writes; memories sit outside this block, so they decode as no-ops
    send(lcdps_pkg::LCDPS_NOP, {2'h0, lcdps_pkg::REV_FIRST_ADR}, 5'h00);
    send(lcdps_pkg::LCDPS_NOP, lcdps_pkg::BLANK_CHAR, lcdps_pkg::BLANK_GLYPH[4:0]);
    repeat (pwrWait) @(posedge core_clk);
    send(lcdps_pkg::LCDPS_DISP, 8'h00, 5'h01);
    send(lcdps_pkg::LCDPS_ICON, 8'h20, 5'h11);
    send(lcdps_pkg::LCDPS_ICON, 8'h22, 5'h13);
    send(lcdps_pkg::LCDPS_ICON, 8'h21, 5'h10);
    send(lcdps_pkg::LCDPS_ICON, 8'h23, 5'h12);
    initDone = 1'b1;
  endtask : init_seq

  // Display off, icons cleared, oscillator stopped, supply off
  task automatic sleep_seq();
    send(lcdps_pkg::LCDPS_DISP, 8'h00, 5'h00);
    for (int i = 0; i < 4; i++)
      send(lcdps_pkg::LCDPS_ICON, 8'(8'h20 + i), 5'h00);
    send(lcdps_pkg::LCDPS_PSAVE, 8'h00, 5'h01);
    send(lcdps_pkg::LCDPS_PWR, 8'h00, 5'h00);
  endtask : sleep_seq

  task automatic wake_seq(input int pwrWait);
    send(lcdps_pkg::LCDPS_PSAVE, 8'h00, 5'h02);
    send(lcdps_pkg::LCDPS_PWR, 8'h00, 5'h01);
    repeat (pwrWait) @(posedge core_clk);
    send(lcdps_pkg::LCDPS_DISP, 8'h00, 5'h01);
  endtask : wake_seq
endmodule : lcdps_host

//--- bench/lcdps_sequencer_tb_top.sv
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module lcdps_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct { lcdps_pkg::lcdps_cmd_e c; logic [7:0] a; logic [4:0] d; int s; logic [4:0] e; } lcdps_row_s;
  logic core_clk, rst_n, extClk, useExtClk, displayOn, staticDisplayOn, lowPowerHold, oscRunning;
  logic supplyOn, segmentEnable, supplySettled, ready, dotTick, dotTick4;
  logic [4:0] volume;
  logic [3:0][4:0] iconData;
  lcdps_pkg::lcdps_cmd_s cmdIn;
  lcdps_pkg::lcdps_setup_s setupIn, setupOut;
  int error_cnt = 0, n_tests = 0, cnt, cnt4;
  lcdps_row_s rows[12] = '{
    '{lcdps_pkg::LCDPS_VOLUME, 8'h00, 5'h15, 0, 5'h15}, '{lcdps_pkg::LCDPS_VOLUME, 8'h00, 5'h00, 0, 5'h00},
    '{lcdps_pkg::LCDPS_STATIC, 8'h00, 5'h01, 5, 5'h01}, '{lcdps_pkg::LCDPS_STATIC, 8'h00, 5'h00, 5, 5'h00},
    '{lcdps_pkg::LCDPS_ICON, 8'h21, 5'h1F, 8, 5'h1F}, '{lcdps_pkg::LCDPS_ICON, 8'h24, 5'h05, 8, 5'h1F},
    '{lcdps_pkg::LCDPS_ICON, 8'h1F, 5'h05, 6, 5'h11}, '{lcdps_pkg::LCDPS_NOP, 8'h00, 5'h1F, 0, 5'h00},
    '{lcdps_pkg::LCDPS_PWR, 8'h00, 5'h00, 3, 5'h00}, '{lcdps_pkg::LCDPS_PWR, 8'h00, 5'h01, 3, 5'h01},
    '{lcdps_pkg::LCDPS_PSAVE, 8'h00, 5'h03, 1, 5'h01}, '{lcdps_pkg::LCDPS_PSAVE, 8'h00, 5'h02, 2, 5'h01}};

  // Short counts keep the run brief
  lcdps_sequencer #(.CLK_X4_OPTION(1'b0), .RESET_CYCLES(4), .PWR_CYCLES(8)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .cmdIn(cmdIn), .setupIn(setupIn), .extClk(extClk),
    .useExtClk(useExtClk), .setupOut(setupOut), .displayOn(displayOn), .staticDisplayOn(staticDisplayOn),
    .lowPowerHold(lowPowerHold), .oscRunning(oscRunning), .supplyOn(supplyOn), .volume(volume),
    .iconData(iconData), .segmentEnable(segmentEnable), .supplySettled(supplySettled), .ready(ready),
    .dotTick(dotTick));
  lcdps_host host (.core_clk(core_clk), .ready(ready), .cmdOut(cmdIn));
  // Option build: external clock at four times the dot rate
  lcdps_sequencer #(.CLK_X4_OPTION(1'b1), .RESET_CYCLES(4), .PWR_CYCLES(8)) uut4 (
    .core_clk(core_clk), .rst_n(rst_n), .cmdIn(cmdIn), .setupIn(setupIn), .extClk(extClk),
    .useExtClk(useExtClk), .setupOut(), .displayOn(), .staticDisplayOn(), .lowPowerHold(), .oscRunning(),
    .supplyOn(), .volume(), .iconData(), .segmentEnable(), .supplySettled(), .ready(), .dotTick(dotTick4));

  // ---------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------
  always #2 core_clk = ~core_clk;
  always #10 extClk = ~extClk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] obs(input int s);
    case (s)
      0: return volume;
      1: return {4'h0, lowPowerHold};
      2: return {4'h0, oscRunning};
      3: return {4'h0, supplyOn};
      5: return {4'h0, staticDisplayOn};
      6: return iconData[0];
      default: return iconData[1];
    endcase
  endfunction : obs

  task automatic check_reset();
    `CHK("rst flags", 6'h02, {displayOn, staticDisplayOn, lowPowerHold, supplyOn, oscRunning, ready})
    `CHK("rst volume", 5'h00, volume)
    `CHK("rst icons", 20'h00000, iconData)
    `CHK("rst setup", 7'h03, setupOut)
  endtask : check_reset

  task automatic count_ticks(input int n);
    cnt = 0;
    cnt4 = 0;
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      cnt += (dotTick === 1'b1);
      cnt4 += (dotTick4 === 1'b1);
    end
  endtask : count_ticks

  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 0; extClk = 1; useExtClk = 0; rst_n = 0; setupIn = '0;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1;
    check_reset();
    host.send(lcdps_pkg::LCDPS_VOLUME, 8'h00, 5'h1F);
    `CHK("early cmd", 5'h00, volume)
    `CHK("not done", 1'b0, host.initDone)
    setupIn = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h1};
    host.init_seq(10);
    `CHK("ready", 1'b1, ready)
    `CHK("init done", 1'b1, host.initDone)
    `CHK("setup", setupIn, setupOut)
    `CHK("settled", 1'b1, supplySettled)
    `CHK("icons", 20'h94E11, iconData)
    foreach (rows[i])
    begin
      host.send(rows[i].c, rows[i].a, rows[i].d);
      `CHK("row", rows[i].e, obs(rows[i].s))
    end
    host.send(lcdps_pkg::LCDPS_DISP, 8'h00, 5'h00);
    host.send(lcdps_pkg::LCDPS_DISP, 8'h00, 5'h01);
    `CHK("seg c1", 2'h2, {displayOn, segmentEnable})
    @(posedge core_clk) #1;
    `CHK("seg c2", 1'b1, segmentEnable)
    count_ticks(64);
    `CHK("int ticks", 4, cnt)
    useExtClk = 1;
    count_ticks(128);
    `CHK("ext ticks", 1'b1, cnt >= 25 && cnt <= 26)
    `CHK("x4 ticks", 6, cnt4)
    useExtClk = 0;
    host.sleep_seq();
    `CHK("sleep", 5'h04, {displayOn, segmentEnable, lowPowerHold, oscRunning, supplyOn})
    `CHK("sleep icons", 20'h00000, iconData)
    host.wake_seq(10);
    @(posedge core_clk) #1;
    `CHK("wake", 5'h1B, {displayOn, segmentEnable, lowPowerHold, oscRunning, supplyOn})
    rst_n = 0;
    @(posedge core_clk) #1;
    check_reset();
    rst_n = 1;
    host.send(lcdps_pkg::LCDPS_VOLUME, 8'h00, 5'h1F);
    `CHK("early cmd 2", 5'h00, volume)
    complete_run();
  end
endmodule : lcdps_sequencer_tb_top
